// file: src/cds_serializer.sv
/*
  Character-to-dot video path: dot counter, character latch, graphics and
  ROM mux, dot shifter, sweep and symbol counters, memory prefetch FIFO.
  Assumes a synchronous display RAM with one cycle read latency, an
  asynchronous character ROM, and blanking/sync levels from pins.
*/
`timescale 1ns/100ps
module cds_serializer
  import cds_pkg::*;
#(
  parameter int unsigned ADDR_W = 10,
  parameter int unsigned CHARS  = 64,
  parameter int unsigned SYM_W  = 7,
  parameter int unsigned DEPTH  = FIFO_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 hblank_pin,
  input  wire logic                 vblank_pin,
  input  wire logic                 csync_pin,
  output logic [ADDR_W-1:0]         mem_addr,
  output logic                      mem_rd,
  input  wire logic [CHAR_W-1:0]    mem_rdata,
  output logic [CHAR_W+SWEEP_W-2:0] rom_addr,
  input  wire logic [CELL_DOTS-1:0] rom_data,
  output logic [ADDR_W-1:0]         disp_addr,
  output logic                      eoc,
  output logic                      eoc_n,
  output logic [SYM_W-1:0]          sym_pos,
  output logic [SWEEP_W-1:0]        sweep,
  output logic                      dot_clk,
  output logic                      shift_clk_n,
  output logic                      gfx_sel_n,
  output logic                      video,
  output logic                      blank_out,
  output logic                      sync_out
);

  if (CHARS < 1 || CHARS > (1 << SYM_W) || CHARS >= (1 << ADDR_W))
    $error("cds_serializer: CHARS does not fit SYM_W or ADDR_W");
  if (DEPTH < 2)
    $error("cds_serializer: DEPTH must be at least 2");

  typedef struct packed {
    logic [1:0]           hb_sync;
    logic [1:0]           vb_sync;
    logic [1:0]           cs_sync;
    logic                 hb_d;
    logic [3:0]           dot_cnt;
    logic                 dot_clk;
    logic                 shift_clk_n;
    logic                 eoc;
    logic                 eoc_n;
    logic [SYM_W-1:0]     sym_pos;
    logic [3:0]           sweep;
    logic [ADDR_W-1:0]    row_base;
    logic [ADDR_W-1:0]    fetch_addr;
    logic [ADDR_W-1:0]    disp_addr;
    logic [ADDR_W-1:0]    mem_addr;
    logic                 mem_rd;
    logic                 pend;
    logic [CHAR_W-1:0]    latch;
    logic [CELL_DOTS-1:0] shreg;
    logic                 video;
    logic                 blank_out;
    logic                 sync_out;
  } cds_state_t;

  cds_state_t         s;
  cds_state_t         next_s;

  logic               hb;
  logic               vb;
  logic               blank_rise;
  logic               blank_fall;
  logic               dot_en;
  logic               ev_eoc;
  logic               flush;
  logic               issue;
  logic [ADDR_W-1:0]  nb;
  logic [ADDR_W-1:0]  fetched;
  logic [1:0]         band;
  logic [CELL_DOTS-1:0] gfx_dots;
  logic [CELL_DOTS-1:0] par_dots;

  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [CHAR_W-1:0]  fifo_out_data;

  // prefetch buffer between display memory and the character latch;
  // drained one word per end-of-character, so it stalls during blanking
  cds_fifo #(
    .W     (CHAR_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .flush     (flush),
    .in_valid  (s.pend),
    .in_ready  (fifo_in_ready),
    .in_data   (mem_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (ev_eoc),
    .out_data  (fifo_out_data)
  );

  // synchronised pin levels and edges of horizontal blanking
  always_comb begin
    hb         = s.hb_sync[1];
    vb         = s.vb_sync[1];
    blank_rise = hb & ~s.hb_d;
    blank_fall = ~hb & s.hb_d;
  end

  // dot enable is gated off by horizontal blanking; carry is the strobe;
  // the reload cycle at blank end never carries, even from a stuck 15
  always_comb begin
    dot_en = ~hb;
    ev_eoc = dot_en && !blank_fall && (s.dot_cnt == DOT_LAST);
  end

  // generator inputs come only from the latch and the sweep count
  always_comb begin
    band     = cds_band(s.sweep);
    gfx_dots = cds_gfx_row(s.latch[5:0], band);
    // low select picks graphics, high picks ROM dots
    par_dots = s.latch[CHAR_W-1] ? rom_data : gfx_dots;
  end

  // row base for the coming sweep, and fetch progress along the sweep
  always_comb begin
    nb = s.row_base;
    if (vb)
      nb = '0;
    else if (blank_rise && s.sweep == SWEEP_LAST)
      nb = s.row_base + ADDR_W'(CHARS);
    fetched = s.fetch_addr - s.row_base;
    flush   = blank_rise | vb;
    // one read outstanding at a time; stall while the buffer is full
    issue   = ~flush & fifo_in_ready & ~s.mem_rd & ~s.pend
              & (fetched < ADDR_W'(CHARS));
  end

  // next-state logic for the whole path
  always_comb begin
    next_s = s;

    // two-flop synchronisers, first stage feeds only the second
    next_s.hb_sync = {s.hb_sync[0], hblank_pin};
    next_s.vb_sync = {s.vb_sync[0], vblank_pin};
    next_s.cs_sync = {s.cs_sync[0], csync_pin};
    next_s.hb_d    = hb;

    // dot counter: count dots, preload on carry for a ten-dot cycle
    if (blank_fall)
      next_s.dot_cnt = DOT_RELOAD;
    else if (ev_eoc)
      next_s.dot_cnt = DOT_RELOAD;
    else if (dot_en)
      next_s.dot_cnt = s.dot_cnt + 4'h1;

    // shift clock pins: active-low and active-high copies
    next_s.dot_clk     = dot_en;
    next_s.shift_clk_n = ~dot_en;
    next_s.eoc         = ev_eoc;
    next_s.eoc_n       = ~ev_eoc;

    // symbol counter counts strobes along the sweep
    if (blank_fall)
      next_s.sym_pos = '0;
    else if (ev_eoc)
      next_s.sym_pos = s.sym_pos + 1'b1;

    // sweep counter: one count per sweep, wraps after fifteen
    if (vb)
      next_s.sweep = SWEEP_RST;
    else if (blank_rise) begin
      if (s.sweep == SWEEP_LAST)
        next_s.sweep = SWEEP_RST;
      else
        next_s.sweep = s.sweep + 4'h1;
    end
    next_s.row_base = nb;

    // memory fetch restarts at the row base every sweep, so the same
    // characters feed the generators for all sweeps of a text row
    next_s.pend   = s.mem_rd & ~flush;
    next_s.mem_rd = issue;
    if (flush) begin
      next_s.fetch_addr = nb;
    end else if (issue) begin
      next_s.mem_addr   = s.fetch_addr;
      next_s.fetch_addr = s.fetch_addr + 1'b1;
    end

    // character latch: strobe captures the next character
    if (flush) begin
      next_s.disp_addr = nb;
    end else if (!next_s.eoc_n) begin
      next_s.disp_addr = s.disp_addr + 1'b1;
      if (fifo_out_valid)
        next_s.latch = {~fifo_out_data[CHAR_W-1],
                        fifo_out_data[CHAR_W-2:0]};
      else
        next_s.latch = CHAR_EMPTY;                  // underrun: blank cell
    end

    // dot shifter: parallel load on strobe, else shift while enabled
    if (!next_s.eoc_n)
      next_s.shreg = par_dots;
    else if (dot_en)
      next_s.shreg = {s.shreg[CELL_DOTS-2:0], 1'b0};

    // blanking into video, sync on its own path
    next_s.blank_out = hb | vb;
    next_s.video     = s.shreg[CELL_DOTS-1] & ~(hb | vb);
    next_s.sync_out  = s.cs_sync[1];
  end

  // the one state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s             <= '0;
      s.hb_sync     <= 2'h3;                        // start blanked: no
      s.vb_sync     <= 2'h3;                        // false edge or dots
      s.hb_d        <= 1'b1;                        // after release
      s.dot_cnt     <= DOT_RELOAD;
      s.eoc_n       <= 1'b1;
      s.shift_clk_n <= 1'b1;
      s.latch       <= CHAR_EMPTY;
      s.sweep       <= SWEEP_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state bits
  assign mem_addr    = s.mem_addr;
  assign mem_rd      = s.mem_rd;
  assign rom_addr    = {s.latch[CHAR_W-2:0], s.sweep};
  assign disp_addr   = s.disp_addr;
  assign eoc         = s.eoc;
  assign eoc_n       = s.eoc_n;
  assign sym_pos     = s.sym_pos;
  assign sweep       = s.sweep;
  assign dot_clk     = s.dot_clk;
  assign shift_clk_n = s.shift_clk_n;
  assign gfx_sel_n   = s.latch[CHAR_W-1];
  assign video       = s.video;
  assign blank_out   = s.blank_out;
  assign sync_out    = s.sync_out;

endmodule

// file: src/cds_pkg.sv
/*
  Constants and helper functions for the character-to-dot serializer.
  Assumes a single 40 MHz system clock; no software-visible registers.
*/
// Summary of operation
// - Dot counter is 4-bit, reloads 6 on carry, carries every ten dots.
// - Dot counter carry is the end-of-character strobe, counting the symbol counter.
// - Active-low strobe copy loads the dot shifter and strobes the latch.
// - Latch holds the character; strobe captures next and bumps the address.
// - Stored top bit is inverted in the latch; a stored one selects graphics.
// - Parallel-input mux picks graphics when select is low, else ROM dots.
// - Cell is ten dots by fifteen sweeps; generator inputs steady per text row.
// - Block graphics change only at five-sweep band boundaries.
// - Horizontal blanking stops dot shifting and end-of-character strobes.
// - Shift clock out is active low; an active-high copy also exists.
// - Blanking joins video apart from composite sync, which passes regardless.
// - Display path runs from the system clock alone, no bus transactions.
// - Sweep counter counts sweeps and resets on every fifteenth sweep.
package cds_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned DOT_CNT_W     = 4;
  localparam int unsigned CELL_DOTS     = 10;
  localparam int unsigned CELL_SWEEPS   = 15;
  localparam int unsigned BAND_SWEEPS   = 5;
  localparam int unsigned CHAR_W        = 8;
  localparam int unsigned SWEEP_W       = 4;
  localparam int unsigned FIFO_DEPTH    = 16;

  localparam logic [3:0] DOT_RELOAD = 4'h6;
  localparam logic [3:0] DOT_LAST   = 4'hf;
  localparam logic [3:0] SWEEP_LAST = 4'he;
  localparam logic [3:0] SWEEP_RST  = 4'h0;
  localparam logic [4:0] BAND_EDGE1 = 5'h05;
  localparam logic [4:0] BAND_EDGE2 = 5'h0a;
  // space code with the top bit already inverted: ROM path
  localparam logic [7:0] CHAR_EMPTY = 8'ha0;

  // band of the cell (0..2) for a sweep number
  function automatic logic [1:0] cds_band(input logic [3:0] sweep);
    logic [4:0] sw;
    sw = {1'b0, sweep};
    if (sw < BAND_EDGE1)
      cds_band = 2'h0;
    else if (sw < BAND_EDGE2)
      cds_band = 2'h1;
    else
      cds_band = 2'h2;
  endfunction

  // block-graphics row: two halves, each lit by one code bit per band
  function automatic logic [CELL_DOTS-1:0] cds_gfx_row(
    input logic [5:0] code,
    input logic [1:0] band
  );
    logic l;
    logic r;
    l = code[{band, 1'b0}];
    r = code[{band, 1'b1}];
    cds_gfx_row = {{(CELL_DOTS/2){l}}, {(CELL_DOTS/2){r}}};
  endfunction

endpackage

// file: src/cds_fifo.sv
/*
  Parameterised synchronous FIFO with valid/ready on both sides and flush.
  Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/100ps
module cds_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1)
    $error("cds_fifo: DEPTH must be a power of two >= 2");

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } cds_fifo_t;

  cds_fifo_t s;
  cds_fifo_t next_s;
  logic      push;
  logic      pop;

  // honest flags from the occupancy count
  assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update; flush drops everything
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = s.wr + 1'b1;
    end
    if (pop)
      next_s.rd = s.rd + 1'b1;
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      next_s.wr  = '0;
      next_s.rd  = '0;
      next_s.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// file: verif/cds_mem_model.sv
/*
  Display RAM and character ROM seen from the serializer's memory ports.
  Assumes one clock; RAM answers the cycle after a read pulse.
*/
`timescale 1ns/100ps
module cds_mem_model (
  input  wire logic        clk,
  input  wire logic [9:0]  mem_addr,
  input  wire logic        mem_rd,
  output logic      [7:0]  mem_rdata = 8'h5a,
  input  wire logic [10:0] rom_addr,
  output logic      [9:0]  rom_data
);
  // ram data only valid one cycle after a read, junk otherwise
  always @(posedge clk) begin
    if (mem_rd)
      mem_rdata <= mem_addr[7:0] * 8'h2d + 8'h13;
    else
      mem_rdata <= ~mem_rdata;
  end

  // rom dots are a plain slice of the address
  assign rom_data = rom_addr[10:1];
endmodule

// file: verif/cds_serializer_checker.sv
/*
  Port-level timing checks for the serializer.
  Assumes a bind onto cds_serializer; one clock domain.
*/
`timescale 1ns/100ps
module cds_serializer_checker
  import cds_pkg::*;
#(
  parameter int unsigned SYM_W = 7
) (
  input wire logic                      clk,
  input wire logic                      nrst,
  input wire logic                      csync_pin,
  input wire logic                      mem_rd,
  input wire logic [CHAR_W+SWEEP_W-2:0] rom_addr,
  input wire logic                      eoc,
  input wire logic                      eoc_n,
  input wire logic [SYM_W-1:0]          sym_pos,
  input wire logic [SWEEP_W-1:0]        sweep,
  input wire logic                      dot_clk,
  input wire logic                      shift_clk_n,
  input wire logic                      gfx_sel_n,
  input wire logic                      video,
  input wire logic                      blank_out,
  input wire logic                      sync_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [3:0] dots_since;
  logic       dots_run;

  // dot cycles since the last strobe; void once the dots stop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dots_since <= 4'h0;
      dots_run   <= 1'b0;
    end else if (eoc && dot_clk) begin
      dots_since <= 4'h0;
      dots_run   <= 1'b1;
    end else if (!dot_clk) begin
      dots_run   <= 1'b0;
    end else if (dots_since != 4'hf) begin
      dots_since <= dots_since + 4'h1;
    end
  end

  a_eoc_period: assert property (
    dots_run && dot_clk && (dots_since == 4'h9) |-> eoc)
    else $error("strobe not ten dots apart");
  a_eoc_gap: assert property (eoc |=> !eoc [*8])
    else $error("strobe too soon");
  a_eoc_pair: assert property (eoc_n == !eoc)
    else $error("strobe copies disagree");
  a_eoc_dot: assert property (eoc |-> $past(dot_clk))
    else $error("strobe without a dot");
  a_sym_step: assert property (
    eoc |-> sym_pos == $past(sym_pos) + 1'b1)
    else $error("symbol count not stepped");
  a_latch_hold: assert property ($changed(rom_addr[10:4]) |-> eoc)
    else $error("latch moved off strobe");
  a_gfx_hold: assert property ($changed(gfx_sel_n) |-> eoc)
    else $error("select moved off strobe");
  a_rom_sweep: assert property (rom_addr[3:0] == sweep)
    else $error("rom row not sweep");
  a_sweep_max: assert property (sweep <= SWEEP_LAST)
    else $error("sweep past last");
  a_shift_inv: assert property (shift_clk_n == !dot_clk)
    else $error("shift clock not inverse");
  a_blank_dark: assert property (blank_out |-> !video)
    else $error("video during blank");
  a_sync_pass: assert property (sync_out == $past(csync_pin, 3))
    else $error("sync not passed");
  a_rd_space: assert property (mem_rd |=> !mem_rd)
    else $error("reads too close");
endmodule

bind cds_serializer cds_serializer_checker #(.SYM_W(SYM_W)) u_chk (
  .clk, .nrst, .csync_pin, .mem_rd, .rom_addr, .eoc, .eoc_n, .sym_pos,
  .sweep, .dot_clk, .shift_clk_n, .gfx_sel_n, .video, .blank_out,
  .sync_out);

// file: verif/tb_cds_serializer.sv
/*
  Self-checking bench: reset, then whole sweeps of dots and blanking.
  Assumes the memory model beside the design; default parameters.
*/
`timescale 1ns/100ps
module tb_cds_serializer;
  logic        clk, nrst, hblank_pin, vblank_pin, csync_pin;
  logic [9:0]  mem_addr, disp_addr, rom_data;
  logic [7:0]  mem_rdata;
  logic [10:0] rom_addr;
  logic [6:0]  sym_pos;
  logic [3:0]  sweep;
  logic        mem_rd, eoc, eoc_n, dot_clk, shift_clk_n;
  logic        gfx_sel_n, video, blank_out, sync_out;
  int          miscompares = 0;
  int          tests_run = 0;

  cds_serializer DUT (
    .clk, .nrst, .hblank_pin, .vblank_pin, .csync_pin, .mem_addr, .mem_rd,
    .mem_rdata, .rom_addr, .rom_data, .disp_addr, .eoc, .eoc_n, .sym_pos,
    .sweep, .dot_clk, .shift_clk_n, .gfx_sel_n, .video, .blank_out,
    .sync_out);
  cds_mem_model u_mem (.clk, .mem_addr, .mem_rd, .mem_rdata, .rom_addr,
    .rom_data);

  task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ram contents as the model holds them
  function automatic logic [7:0] mem_val(input int a);
    mem_val = 8'(a * 45 + 19);
  endfunction

  // expected dots of one cell row, first dot in the top bit
  function automatic logic [9:0] dots(input logic [7:0] c, input int sw);
    int b;
    b = (sw < 5) ? 0 : (sw < 10) ? 2 : 4;
    if (c[7])
      dots = {{5{c[b]}}, {5{c[b+1]}}};
    else
      dots = {c[6:0], 3'(sw >> 1)};
  endfunction

  // levels held during reset
  task automatic t_reset();
    check_vec({eoc, eoc_n, shift_clk_n}, 16'h3);
    check_vec({gfx_sel_n, video}, 16'h2);
    check_vec(rom_addr, {5'h0, 7'h20, 4'h0});
    check_vec(sweep, 16'h0);
  endtask

  // one visible sweep of 20 cells, then blanking
  task automatic t_line(input int j);
    int sw, base, k, n, i;
    logic [7:0] c;
    logic [9:0] got;
    sw = j % 15;
    base = (j / 15) * 64;
    check_vec(sweep, 16'(sw));
    hblank_pin = 1'b0;
    fork
      begin
        repeat (210) @(negedge clk);
        hblank_pin = 1'b1;
        csync_pin = 1'b1;
      end
      // a cell's dots show one cycle after its load; the last dot of a
      // cell stands at the next strobe
      for (k = 1; k <= 20; k++) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (eoc !== 1'b1 && n < 30);
        if (k > 1)
          check_vec(n, 16'h1);
        got[0] = video;
        if (k > 2)
          check_vec(got, dots(mem_val(base + k - 3), sw));
        c = mem_val(base + k - 1);
        check_vec({gfx_sel_n, rom_addr[10:4]}, c ^ 8'h80);
        check_vec(disp_addr, 16'(base + k));
        check_vec(sym_pos, 16'(k));
        check_vec({dot_clk, shift_clk_n, eoc_n}, 16'h4);
        for (i = 9; i >= 1; i--) begin
          @(negedge clk);
          got[i] = video;
        end
      end
    join
    repeat (6) @(negedge clk);
    for (k = 0; k < 50; k++) begin
      @(negedge clk);
      check_vec({eoc, video, blank_out}, 16'h1);
      check_vec({dot_clk, shift_clk_n, sync_out}, 16'h3);
    end
    csync_pin = 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // reset, a vertical blank to reach row 0, then sweeps across two rows
  initial begin
    nrst = 1'b0;
    hblank_pin = 1'b1;
    vblank_pin = 1'b1;
    csync_pin = 1'b0;
    repeat (20) @(negedge clk);
    t_reset();
    nrst = 1'b1;
    repeat (40) @(negedge clk);
    vblank_pin = 1'b0;
    repeat (40) @(negedge clk);
    for (int j = 0; j < 17; j++)
      t_line(j);
    tally_and_finish();
  end

  // watchdog well beyond 17 sweeps of about 280 cycles
  initial begin
    #300us;
    miscompares++;
    tally_and_finish();
  end
endmodule
